// File: bench/rsoi_insert_bench.sv
// self-checking bench for the section overhead inserter
`timescale 1ns/1ps
module rsoi_insert_bench;
    localparam int N   = 1;
    localparam int ROW = 270 * N;
    localparam int FRM = 9 * ROW;
    logic       mclk, sys_rst, inClockEn, inFrameStart, relayOverhead;
    logic [7:0] inData, traceId, lineData, prevParity;
    logic       lineClock, lineFrameStart;
    int         error_cnt, checks_done;

    rsoi_insert #(.N(N)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .adaptedSectionData(inData), .adaptedClockEn(inClockEn),
        .adaptedFrameStart(inFrameStart), .txTraceIdentifier(traceId),
        .relayOverhead(relayOverhead), .sectionLineData(lineData),
        .sectionLineClock(lineClock), .sectionLineFrameStart(lineFrameStart));
    rsoi_line_sink sink (.mclk(mclk), .lineData(lineData), .lineClock(lineClock),
        .lineFrameStart(lineFrameStart));

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic test_reset_and_unframed();
        check8(lineData, 8'h00);
        check8({6'h00, lineClock, lineFrameStart}, 8'h00);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk) inClockEn <= 1'b1;
        inClockEn <= 1'b0;
        repeat (3) @(posedge mclk);
        check8(8'(sink.rxBytes.size()), 8'h00);  // unframed bytes are dropped
        $display("test reset_and_unframed done");
    endtask

    // len below FRM cuts the frame short; the next start re-aligns
    task automatic send_frame(input int frm, input logic relay, input int gap,
                              input int len);
        logic [7:0] exp[$];
        logic [7:0] d, k, par, tr;
        logic [6:0] s;
        par = 8'h00;
        s = 7'h7F;
        tr = 8'h3C + 8'(frm);
        sink.rxBytes.delete();
        sink.fsAt.delete();
        relayOverhead <= relay;
        traceId <= tr;
        for (int i = 0; i < len; i++) begin
            d = 8'(i * 5 + frm * 3);
            inData <= d;
            inClockEn <= 1'b1;
            inFrameStart <= (i == 0);
            @(posedge mclk);
            if (gap > 0) begin
                inClockEn <= 1'b0;
                repeat (gap) @(posedge mclk);
            end
            if (i < 3 * N) k = 8'hF6;
            else if (i < 6 * N) k = 8'h28;
            else if (i == 6 * N) k = tr;
            else if (i == ROW) k = prevParity;
            else k = d;
            if (relay && i <= 6 * N) k = d;
            if (i == 9 * N) s = 7'h7F;
            if (i >= 9 * N) begin
                for (int b = 7; b >= 0; b--) begin
                    k[b] = k[b] ^ s[6];
                    s = {s[5:0], s[6] ^ s[5]};
                end
            end
            par = par ^ k;
            exp.push_back(k);
        end
        inClockEn <= 1'b0;
        inFrameStart <= 1'b0;
        repeat (2) @(posedge mclk);
        check8(8'(sink.rxBytes.size() == len), 8'h01);
        check8(8'(sink.fsAt.size() == 1 && sink.fsAt[0] == 0), 8'h01);
        for (int i = 0; i < sink.rxBytes.size() && i < len; i++) begin
            check8(sink.rxBytes[i], exp[i]);
        end
        prevParity = par;
        $display("test frame %0d relay %0b gap %0d len %0d done", frm, relay, gap, len);
    endtask

    // --------------------------------------------------------------
    // clock, sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        sys_rst = 1'b1;
        inData = 8'h00;
        inClockEn = 1'b0;
        inFrameStart = 1'b0;
        relayOverhead = 1'b0;
        traceId = 8'h00;
        prevParity = 8'h00;
        error_cnt = 0;
        checks_done = 0;
        repeat (8) @(posedge mclk);
        test_reset_and_unframed();
        send_frame(1, 1'b0, 0, FRM);
        send_frame(2, 1'b0, 1, FRM);
        send_frame(3, 1'b1, 0, 500);
        send_frame(4, 1'b1, 0, FRM);
        send_frame(5, 1'b0, 0, FRM);
        end_of_test();
    end

    // about 12700 cycles are needed; more than twice that means a hang
    initial begin
        repeat (30000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end
endmodule

// File: bench/rsoi_line_sink.sv
// line-side sink model standing in for the receiver of the section line stream
`timescale 1ns/1ps
module rsoi_line_sink (
    // clock
    input wire logic       mclk,
    // line side of the inserter
    input wire logic [7:0] lineData,
    input wire logic       lineClock,
    input wire logic       lineFrameStart
);
    logic [7:0] rxBytes[$];
    int         fsAt[$];
    // --------------------------------------------------------------
    // capture
    // --------------------------------------------------------------
    // no backpressure exists here, so every strobe is taken at once
    always @(posedge mclk) begin
        if (lineFrameStart === 1'b1) begin
            fsAt.push_back(rxBytes.size());
        end
        if (lineClock === 1'b1) begin
            rxBytes.push_back(lineData);
        end
    end
endmodule

// File: design/rsoi_defines.svh
// timing, position and reset constants for the section overhead inserter
`ifndef RSOI_DEFINES_SVH
`define RSOI_DEFINES_SVH
`define RSOI_FRAME_US        125
`define RSOI_CLK_MHZ         10
`define RSOI_FRAME_CYC       (`RSOI_FRAME_US * `RSOI_CLK_MHZ)
`define RSOI_ROWS            9
`define RSOI_OH_COLS         9
`define RSOI_COLS_PER_N      270
`define RSOI_FRAMING_1       8'hF6
`define RSOI_FRAMING_2       8'h28
`define RSOI_SCR_SEED        7'h7F
`define RSOI_TRACE_GROUP     7
`define RSOI_PARITY_ROW      1
`define RSOI_DATA_RESET      8'h00
`endif

// File: design/rsoi_insert.sv
// section overhead insertion, parity generation and scrambling, source side
// Operation
// [RULE_01] byte stream with codirectional clock, 125 us frames
// [RULE_02] output overhead holds framing, trace, parity, orderwire, user, dcc, national bytes
// [RULE_03] trace, parity, orderwire, user, dcc only in first interleaved column
// [RULE_04] generate 3xN of each framing byte in first overhead row
// [RULE_05] overwrite framing, trace, parity; pass other overhead and payload unchanged
// [RULE_06] upstream supplies reference-timed frames with valid overhead bytes
// [RULE_07] scramble only after framing, trace and parity bytes are written
// [RULE_08] first overhead row unscrambled, all other bytes scrambled
// [RULE_09] management trace identifier placed in the trace byte position
// [RULE_10] parity byte is bit interleaved even parity over eight bits
// [RULE_11] parity covers previous whole frame as output, after scrambling
// [RULE_12] previous frame parity written into parity byte before scrambling
// [RULE_13] optional relay of framing and trace bytes in regenerator use
// [RULE_14] scrambler x^7+x^6+1 preset all ones after first overhead row
// [RULE_15] framing byte values F6 and 28 hexadecimal
// [RULE_16] output frame aligned to input frame start, parity reset each frame
`timescale 1ns/1ps
`include "rsoi_defines.svh"
module rsoi_insert #(
    parameter int N = 1
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // adapted frames from the multiplex side
    input  wire logic [7:0] adaptedSectionData,
    input  wire logic       adaptedClockEn,
    input  wire logic       adaptedFrameStart,
    // management
    input  wire logic [7:0] txTraceIdentifier,
    input  wire logic       relayOverhead,
    // line side
    output logic [7:0]      sectionLineData,
    output logic            sectionLineClock,
    output logic            sectionLineFrameStart
);
    localparam int COLS = `RSOI_COLS_PER_N * N;
    localparam int OHW  = `RSOI_OH_COLS * N;

    initial begin
        if (N < 1 || N > 64) begin
            $error("rsoi_insert: N out of range");
        end
    end

    // ------------------------------------------------------------
    // frame position
    // ------------------------------------------------------------
    logic [15:0] col_r;
    logic [3:0]  row_r;
    logic        framed_r;
    logic [15:0] colCur;
    logic [3:0]  rowCur;
    logic        byteEn;

    // position of the byte now on the input; frame start forces origin
    assign colCur = adaptedFrameStart ? 16'h0000 : col_r; // see [RULE_16]
    assign rowCur = adaptedFrameStart ? 4'h0 : row_r;
    assign byteEn = adaptedClockEn && (framed_r || adaptedFrameStart);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            col_r    <= 16'h0000;
            row_r    <= 4'h0;
            framed_r <= 1'b0;
        end else if (byteEn) begin
            framed_r <= 1'b1;
            if (colCur == 16'(COLS - 1)) begin
                col_r <= 16'h0000;
                row_r <= (rowCur == 4'(`RSOI_ROWS - 1)) ? 4'h0 : rowCur + 4'h1;
            end else begin
                col_r <= colCur + 16'h0001;
                row_r <= rowCur;
            end
        end
    end

    // ------------------------------------------------------------
    // overhead decode
    // ------------------------------------------------------------
    logic [15:0] grp;
    logic        inOh;
    logic        firstRow;
    logic        isFrame1;
    logic        isFrame2;
    logic        isTrace;
    logic        isParity;
    logic        seedPos;
    logic        newFrame;

    assign grp      = colCur / 16'(N);
    assign inOh     = colCur < 16'(OHW);
    assign firstRow = (rowCur == 4'h0) && inOh; // see [RULE_08]
    assign isFrame1 = firstRow && grp < 16'd3; // see [RULE_04]
    assign isFrame2 = firstRow && grp >= 16'd3 && grp < 16'd6; // see [RULE_04]
    // only the first interleaved column carries trace and parity
    assign isTrace  = firstRow && colCur == 16'((`RSOI_TRACE_GROUP - 1) * N); // see [RULE_03]
    assign isParity = rowCur == 4'(`RSOI_PARITY_ROW) && colCur == 16'h0000; // see [RULE_03]
    assign seedPos  = rowCur == 4'h0 && colCur == 16'(OHW);
    assign newFrame = adaptedFrameStart && adaptedClockEn;

    // ------------------------------------------------------------
    // byte insertion, then scrambling
    // ------------------------------------------------------------
    rsoi_pkg::rsoi_ovr_t ovrSel;
    logic [7:0] parity_r;
    logic [7:0] parityHeld_r;
    logic [7:0] inserted;
    logic [7:0] scrByte;
    logic [7:0] lineByte;

    assign ovrSel = relayOverhead ? rsoi_pkg::RSOI_OVR_NONE :
                    isFrame1      ? rsoi_pkg::RSOI_OVR_FRAME1 :
                    isFrame2      ? rsoi_pkg::RSOI_OVR_FRAME2 :
                                    rsoi_pkg::RSOI_OVR_NONE; // see [RULE_13]

    always_comb begin
        inserted = adaptedSectionData; // see [RULE_05]
        unique case (ovrSel)
            rsoi_pkg::RSOI_OVR_FRAME1: inserted = `RSOI_FRAMING_1; // see [RULE_15]
            rsoi_pkg::RSOI_OVR_FRAME2: inserted = `RSOI_FRAMING_2; // see [RULE_15]
            rsoi_pkg::RSOI_OVR_NONE: begin
                if (isTrace && !relayOverhead) begin
                    inserted = txTraceIdentifier; // see [RULE_09]
                end else if (isParity) begin
                    inserted = parityHeld_r; // see [RULE_12]
                end
            end
            default: inserted = adaptedSectionData;
        endcase
    end

    rsoi_scrambler u_scr (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .seedLoad (seedPos),
        .advance  (byteEn && !firstRow),
        .scrByte  (scrByte)
    );

    // scrambling applies to the already inserted byte
    assign lineByte = firstRow ? inserted : inserted ^ scrByte; // see [RULE_07] [RULE_08]

    // ------------------------------------------------------------
    // parity over the output stream
    // ------------------------------------------------------------
    // even parity: xor of all bytes makes each bit column even
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            parity_r     <= 8'h00;
            parityHeld_r <= 8'h00;
        end else if (byteEn) begin
            if (newFrame) begin
                parityHeld_r <= parity_r; // see [RULE_11]
                parity_r     <= lineByte; // see [RULE_16] [RULE_10]
            end else begin
                parity_r <= parity_r ^ lineByte; // see [RULE_10] [RULE_11]
            end
        end
    end

    // ------------------------------------------------------------
    // line outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sectionLineData       <= `RSOI_DATA_RESET;
            sectionLineClock      <= 1'b0;
            sectionLineFrameStart <= 1'b0;
        end else begin
            sectionLineClock      <= byteEn; // see [RULE_01]
            sectionLineFrameStart <= newFrame;
            if (byteEn) begin
                sectionLineData <= lineByte; // see [RULE_02]
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic inFr1_r;
    logic inTr_r;
    logic inRow1_r;
    logic [7:0] rawIn_r;
    logic [7:0] trIn_r;
    always_ff @(posedge mclk) begin
        inFr1_r  <= byteEn && isFrame1 && !relayOverhead;
        inTr_r   <= byteEn && isTrace && !relayOverhead;
        inRow1_r <= byteEn && firstRow && !isFrame1 && !isFrame2 && !isTrace;
        rawIn_r  <= adaptedSectionData;
        trIn_r   <= txTraceIdentifier;
    end

    a_framing_one_value: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE_04]
        inFr1_r |-> sectionLineData == 8'hF6)
        else $error("first framing byte wrong");
    a_trace_byte_value: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE_09]
        inTr_r |-> sectionLineData == trIn_r)
        else $error("trace byte not inserted");
    a_first_row_clear: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE_08]
        inRow1_r |-> sectionLineData == rawIn_r)
        else $error("first row byte altered");
    a_clock_follows_en: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE_01]
        byteEn |=> sectionLineClock)
        else $error("line clock missing");
    a_frame_start_out: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE_16]
        newFrame |=> sectionLineFrameStart && sectionLineClock)
        else $error("frame start not forwarded");
    a_parity_latch: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE_11]
        (byteEn && newFrame) |=> parityHeld_r == $past(parity_r))
        else $error("parity not latched");
    a_parity_insert: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE_12]
        (byteEn && isParity) |=> sectionLineData == ($past(parityHeld_r) ^ $past(scrByte)))
        else $error("parity byte wrong");
    a_scramble_applied: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE_07]
        (byteEn && !firstRow && !isParity)
            |=> sectionLineData == ($past(adaptedSectionData) ^ $past(scrByte)))
        else $error("payload not scrambled");

    c_frame_start: cover property (@(posedge mclk) newFrame);
    c_parity_slot: cover property (@(posedge mclk) byteEn && isParity);
    c_relay_mode: cover property (@(posedge mclk) byteEn && isFrame1 && relayOverhead);
endmodule

// File: design/rsoi_pkg.sv
// types shared by the section overhead inserter
package rsoi_pkg;
    typedef enum logic [2:0] {
        RSOI_OVR_NONE    = 3'b001,
        RSOI_OVR_FRAME1  = 3'b010,
        RSOI_OVR_FRAME2  = 3'b100
    } rsoi_ovr_t;
endpackage

// File: design/rsoi_scrambler.sv
// frame synchronous x^7+x^6+1 scrambler sequence generator
`timescale 1ns/1ps
`include "rsoi_defines.svh"
module rsoi_scrambler (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // control
    input  wire logic       seedLoad,
    input  wire logic       advance,
    // sequence byte for the current position
    output logic [7:0]      scrByte
);
    logic [6:0] state_r;
    logic [6:0] state_nxt;
    logic [6:0] seedState;
    logic [6:0] walk [0:8];
    logic [7:0] bits;

    assign seedState = `RSOI_SCR_SEED;
    assign walk[0] = seedLoad ? seedState : state_r;
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            assign bits[7-i]  = walk[i][6];
            assign walk[i+1]  = {walk[i][5:0], walk[i][6] ^ walk[i][5]};
        end
    endgenerate
    assign scrByte   = bits;
    assign state_nxt = walk[8];

    // preset on the first scrambled byte, msb of the byte first
    always_ff @(posedge mclk) begin // see [RULE_14]
        if (sys_rst) begin
            state_r <= `RSOI_SCR_SEED;
        end else if (advance) begin
            state_r <= state_nxt;
        end
    end
endmodule
